/* File: rtl/tcps_pkg.sv */
// Purpose: constants and carriers for the timer clock prescale select block
// Assumes: 8-bit special-function-register port from the cpu core
// Notes: registers reset to zero
//
// Notes on behaviour
// - timer0 select 0 prescaled, 1 system clock
// - timer1 select 0 prescaled, 1 system clock
// - prescale codes divide by 12, 4, 48
// - external clock divided by eight, synchronised
// - prescale affects only prescaled-select timers
// - config upper nibble reads zero, ignores writes
// - timer1 low byte read/write at 0x8B
// - timer0 high byte at 0x8C, resets zero
// - timer1 high byte at 0x8D, resets zero
// - split timer0 upper counter follows timer0 select, external included
package tcps_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_CLK_CFG = 8'h8E;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_CFG = 4'h0;
  // config field positions
  localparam int POS_T1_SEL = 3;
  localparam int POS_T0_SEL = 2;
  localparam int POS_PRE_HI = 1;
  localparam int POS_PRE_LO = 0;
  // ****************************************
  // prescale divisors
  // ****************************************
  localparam int DIV_CODE0 = 12;
  localparam int DIV_CODE1 = 4;
  localparam int DIV_CODE2 = 48;
  localparam int DIV_EXT = 8;
  localparam logic [5:0] CNT_CODE0 = 6'(DIV_CODE0 - 1);
  localparam logic [5:0] CNT_CODE1 = 6'(DIV_CODE1 - 1);
  localparam logic [5:0] CNT_CODE2 = 6'(DIV_CODE2 - 1);
  localparam logic [2:0] CNT_EXT = 3'(DIV_EXT - 1);
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam logic [2:0] EXT_ZERO = 3'h0;

  typedef enum logic [1:0] {
    TCPS_DIV12,
    TCPS_DIV4,
    TCPS_DIV48,
    TCPS_EXT8
  } tcps_pre_e;

  // special-function-register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcps_sfr_s;

  // per-timer count ticks
  typedef struct packed {
    logic t0_tick;
    logic t1_tick;
    logic t0_split_tick;
  } tcps_tick_s;
endpackage

/* File: rtl/tcps_top.sv */
// Purpose: timer clock prescaler, per-timer clock select, timer byte registers
// Assumes: sfr access from cpu on clk; ext_clk is an asynchronous pin
// Notes: ticks are one-cycle enables on clk; counting is done by the timer core,
//        which loads the byte registers back through the cnt_* ports
module tcps_top
  import tcps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // special-function-register port
  input wire tcps_sfr_s sfr,
  output logic [7:0] sfr_rdata,
  // external clock pin
  input wire logic ext_clk,
  // count updates from the timer core
  input wire logic cnt_t1_low_we,
  input wire logic [7:0] cnt_t1_low,
  input wire logic cnt_t0_high_we,
  input wire logic [7:0] cnt_t0_high,
  input wire logic cnt_t1_high_we,
  input wire logic [7:0] cnt_t1_high,
  // byte registers and ticks to the timer core
  output logic [7:0] t1_low,
  output logic [7:0] t0_high,
  output logic [7:0] t1_high,
  output tcps_tick_s ticks
);
  // ****************************************
  // state
  // ****************************************
  logic [3:0] cfg_ff;
  logic [7:0] t1_low_ff, t0_high_ff, t1_high_ff, rdata_ff;
  logic [5:0] pre_cnt_ff;
  logic [2:0] ext_cnt_ff;
  logic ext_s1_ff, ext_s2_ff, ext_prev_ff, ext_div_ff;
  logic pre_tick_ff;
  tcps_tick_s ticks_ff;

  // ****************************************
  // register decode
  // ****************************************
  wire logic wr_cfg = sfr.wr && (sfr.addr == ADDR_CLK_CFG);
  wire logic wr_t1l = sfr.wr && (sfr.addr == ADDR_T1_LOW);
  wire logic wr_t0h = sfr.wr && (sfr.addr == ADDR_T0_HIGH);
  wire logic wr_t1h = sfr.wr && (sfr.addr == ADDR_T1_HIGH);
  wire logic t1_sel = cfg_ff[POS_T1_SEL];
  wire logic t0_sel = cfg_ff[POS_T0_SEL];
  wire tcps_pre_e pre_mode = tcps_pre_e'(cfg_ff[POS_PRE_HI:POS_PRE_LO]);
  wire logic [7:0] nxt_rdata =
    (sfr.addr == ADDR_CLK_CFG) ? {4'h0, cfg_ff} :
    (sfr.addr == ADDR_T1_LOW) ? t1_low_ff :
    (sfr.addr == ADDR_T0_HIGH) ? t0_high_ff :
    (sfr.addr == ADDR_T1_HIGH) ? t1_high_ff : 8'h00;

  // config register, upper nibble never stored
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cfg_ff <= RST_CFG;
    else if (wr_cfg)
      cfg_ff <= sfr.wdata[3:0];
  end

  // byte registers: cpu write has priority over core update
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      t1_low_ff <= RST_BYTE;
      t0_high_ff <= RST_BYTE;
      t1_high_ff <= RST_BYTE;
    end
    else
    begin
      if (wr_t1l)
        t1_low_ff <= sfr.wdata;
      else if (cnt_t1_low_we)
        t1_low_ff <= cnt_t1_low;
      if (wr_t0h)
        t0_high_ff <= sfr.wdata;
      else if (cnt_t0_high_we)
        t0_high_ff <= cnt_t0_high;
      if (wr_t1h)
        t1_high_ff <= sfr.wdata;
      else if (cnt_t1_high_we)
        t1_high_ff <= cnt_t1_high;
    end
  end

  // read data registered, valid one cycle after address
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata_ff <= RST_BYTE;
    else
      rdata_ff <= nxt_rdata;
  end

  // ****************************************
  // system clock prescaler
  // ****************************************
  // terminal count per prescale code
  wire logic [5:0] pre_last =
    (pre_mode == TCPS_DIV4) ? CNT_CODE1 :
    (pre_mode == TCPS_DIV48) ? CNT_CODE2 : CNT_CODE0;
  // >= so a switch to a shorter divisor wraps at once, not after a 6-bit rollover
  wire logic pre_wrap = (pre_cnt_ff >= pre_last);
  wire logic [5:0] nxt_pre_cnt = pre_wrap ? CNT_ZERO : pre_cnt_ff + 6'h01;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pre_cnt_ff <= CNT_ZERO;
    else
      pre_cnt_ff <= nxt_pre_cnt;
  end

  // ****************************************
  // external clock divide by eight
  // ****************************************
  // two-flop synchroniser on the pin
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end
    else
    begin
      ext_s1_ff <= ext_clk;
      ext_s2_ff <= ext_s1_ff;
      ext_prev_ff <= ext_s2_ff;
    end
  end

  wire logic ext_rise = ext_s2_ff && !ext_prev_ff;
  wire logic [2:0] nxt_ext_cnt = ext_rise ? ext_cnt_ff + 3'h1 : ext_cnt_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ext_cnt_ff <= EXT_ZERO;
      ext_div_ff <= 1'b0;
    end
    else
    begin
      ext_cnt_ff <= nxt_ext_cnt;
      ext_div_ff <= ext_rise && (ext_cnt_ff == CNT_EXT);
    end
  end

  // ****************************************
  // tick selection
  // ****************************************
  // code 11 uses external divided clock
  wire logic nxt_pre_tick = (pre_mode == TCPS_EXT8) ? ext_div_ff : pre_wrap;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pre_tick_ff <= 1'b0;
    else
      pre_tick_ff <= nxt_pre_tick;
  end

  wire logic nxt_t0_tick = t0_sel ? 1'b1 : pre_tick_ff;
  wire logic nxt_t1_tick = t1_sel ? 1'b1 : pre_tick_ff;
  // split upper counter, same source as timer0 including external
  wire logic nxt_split_tick = t0_sel ? 1'b1 : pre_tick_ff;

  // registered ticks cost a cycle of latency but keep every output on a flop
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ticks_ff <= '0;
    else
      ticks_ff <= '{t0_tick: nxt_t0_tick, t1_tick: nxt_t1_tick,
                    t0_split_tick: nxt_split_tick};
  end

  // outputs straight from flops
  assign sfr_rdata = rdata_ff;
  assign t1_low = t1_low_ff;
  assign t0_high = t0_high_ff;
  assign t1_high = t1_high_ff;
  assign ticks = ticks_ff;

  // ****************************************
  // assertions
  // ****************************************
  // upper nibble read zero
  a_cfg_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sfr.addr) == ADDR_CLK_CFG |-> sfr_rdata[7:4] == 4'h0)
    else $error("config upper nibble not zero");

  a_cfg_write_mask: assert property (@(posedge clk) disable iff (sys_rst)
    wr_cfg |=> cfg_ff == $past(sfr.wdata[3:0]))
    else $error("config write not stored as low nibble");

  a_t0_sys_tick: assert property (@(posedge clk) disable iff (sys_rst)
    t0_sel [*2] |-> ticks.t0_tick)
    else $error("timer0 missed system tick");

  a_t1_sys_tick: assert property (@(posedge clk) disable iff (sys_rst)
    t1_sel [*2] |-> ticks.t1_tick)
    else $error("timer1 missed system tick");

  a_t0_prescaled: assert property (@(posedge clk) disable iff (sys_rst)
    !t0_sel |=> ticks.t0_tick == $past(pre_tick_ff))
    else $error("timer0 prescaled tick mismatch");

  a_t1_prescaled: assert property (@(posedge clk) disable iff (sys_rst)
    !t1_sel |=> ticks.t1_tick == $past(pre_tick_ff))
    else $error("timer1 prescaled tick mismatch");

  a_split_source: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> ticks.t0_split_tick == ($past(t0_sel) || $past(pre_tick_ff)))
    else $error("split counter tick from wrong source");

  a_div4_gap: assert property (@(posedge clk) disable iff (sys_rst)
    (pre_mode == TCPS_DIV4) && pre_wrap ##1 (pre_mode == TCPS_DIV4) [*4] |->
      pre_wrap && !$past(pre_wrap, 1) && !$past(pre_wrap, 2) && !$past(pre_wrap, 3))
    else $error("divide by four period wrong");

  a_div12_gap: assert property (@(posedge clk) disable iff (sys_rst)
    (pre_mode == TCPS_DIV12) && pre_wrap ##1 (pre_mode == TCPS_DIV12) [*8]
      ##1 (pre_mode == TCPS_DIV12) [*4] |->
      pre_wrap && !$past(pre_wrap, 1) && !$past(pre_wrap, 11))
    else $error("divide by twelve period wrong");

  a_div48_gap: assert property (@(posedge clk) disable iff (sys_rst)
    (pre_mode == TCPS_DIV48) && pre_wrap ##1 (pre_mode == TCPS_DIV48) [*8]
      ##1 (pre_mode == TCPS_DIV48) [*8] ##1 (pre_mode == TCPS_DIV48) [*8]
      ##1 (pre_mode == TCPS_DIV48) [*8] ##1 (pre_mode == TCPS_DIV48) [*8]
      ##1 (pre_mode == TCPS_DIV48) [*8] |->
      pre_wrap && !$past(pre_wrap, 1) && !$past(pre_wrap, 47))
    else $error("divide by forty-eight period wrong");

  a_ext_select: assert property (@(posedge clk) disable iff (sys_rst)
    (pre_mode == TCPS_EXT8) && ext_div_ff ##1 (pre_mode == TCPS_EXT8) |-> pre_tick_ff)
    else $error("external divided tick lost");

  a_ext_sync: assert property (@(posedge clk) disable iff (sys_rst)
    ext_rise |-> $past(ext_clk, 2))
    else $error("external edge bypassed synchroniser");

  a_ext_every8: assert property (@(posedge clk) disable iff (sys_rst)
    ext_div_ff |-> ext_cnt_ff == EXT_ZERO)
    else $error("external divide tick off count");

  a_t0h_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_t0h |=> t0_high == $past(sfr.wdata))
    else $error("timer0 high write lost");

  a_t1h_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_t1h |=> t1_high == $past(sfr.wdata))
    else $error("timer1 high write lost");

  a_t1l_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_t1l |=> t1_low == $past(sfr.wdata))
    else $error("timer1 low write lost");

  // core update lands when cpu idle
  a_t1l_core: assert property (@(posedge clk) disable iff (sys_rst)
    cnt_t1_low_we && !wr_t1l |=> t1_low == $past(cnt_t1_low))
    else $error("timer1 low core update lost");

  // core update lands when cpu idle
  a_t1h_core: assert property (@(posedge clk) disable iff (sys_rst)
    cnt_t1_high_we && !wr_t1h |=> t1_high == $past(cnt_t1_high))
    else $error("timer1 high core update lost");

  a_reset_zero: assert property (@(posedge clk)
    sys_rst |=> t0_high == RST_BYTE && t1_high == RST_BYTE && ticks == '0)
    else $error("registers not clear after reset");
endmodule

/* File: dv/tb_top.sv */
// Purpose: self-checking bench for the timer clock prescale select block
// Assumes: clk at 10 MHz, synchronous active-high reset, sfr reads need no strobe
// Notes: inputs change by non-blocking assignment at the rising edge
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tcps_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  tcps_sfr_s sfr = '0;
  logic [7:0] sfr_rdata, t1_low, t0_high, t1_high;
  logic ext_clk = 1'b0;
  logic ext_run = 1'b0;
  logic [1:0] ext_cnt = 2'h0;
  logic t1l_we = 1'b0, t0h_we = 1'b0, t1h_we = 1'b0;
  logic [7:0] t1l_d = 8'h00, t0h_d = 8'h00, t1h_d = 8'h00;
  tcps_tick_s ticks;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  tcps_top dut_u (.clk(clk), .sys_rst(sys_rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .ext_clk(ext_clk), .cnt_t1_low_we(t1l_we), .cnt_t1_low(t1l_d),
    .cnt_t0_high_we(t0h_we), .cnt_t0_high(t0h_d), .cnt_t1_high_we(t1h_we),
    .cnt_t1_high(t1h_d), .t1_low(t1_low), .t0_high(t0_high), .t1_high(t1_high),
    .ticks(ticks));

  // clock, external pin of period four clocks while running, hang guard
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (ext_run)
      ext_cnt <= ext_cnt + 2'h1;
    ext_clk <= ext_cnt[1];
    if (cycles == 20000)
    begin
      miscompares++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    sfr <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk);
    sfr.wr <= 1'b0;
  endtask

  // read takes one cycle after the address is presented
  task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    sfr <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk);
    @(negedge clk);
    check(what, sfr_rdata, exp);
  endtask

  // cycles between two ticks of one bit, then the tick pattern at that tick
  task automatic period_chk(input int b, input logic [7:0] exp, input logic [2:0] msk);
    int n;
    repeat (3)
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
      end while (ticks[b] !== 1'b1 && n < 400);
    end
    check("tick period", 8'(n), exp);
    check("tick pattern", {5'h0, ticks & msk}, {5'h0, 3'b111 & msk});
  endtask

  task automatic t_reset;
    rd_chk("cfg reset", ADDR_CLK_CFG, 8'h00);
    rd_chk("t0_high reset", ADDR_T0_HIGH, 8'h00);
    rd_chk("t1_high reset", ADDR_T1_HIGH, 8'h00);
    rd_chk("unmapped", 8'h80, 8'h00);
    check("t0_high port", t0_high, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(ADDR_T1_LOW, 8'hA5);
    wr(ADDR_T0_HIGH, 8'h3C);
    wr(ADDR_T1_HIGH, 8'hC3);
    wr(ADDR_CLK_CFG, 8'hF0);
    rd_chk("t1_low", ADDR_T1_LOW, 8'hA5);
    rd_chk("t0_high", ADDR_T0_HIGH, 8'h3C);
    rd_chk("t1_high", ADDR_T1_HIGH, 8'hC3);
    rd_chk("cfg upper", ADDR_CLK_CFG, 8'h00);
    check("t1_low port", t1_low, 8'hA5);
    check("t0_high port", t0_high, 8'h3C);
    check("t1_high port", t1_high, 8'hC3);
    wr(ADDR_CLK_CFG, 8'hFF);
    rd_chk("cfg mask", ADDR_CLK_CFG, 8'h0F);
    $display("test registers done");
  endtask

  task automatic t_core;
    @(posedge clk);
    t1l_we <= 1'b1;
    t1l_d <= 8'h5A;
    t1h_we <= 1'b1;
    t1h_d <= 8'h69;
    sfr <= '{wr: 1'b1, rd: 1'b0, addr: ADDR_T0_HIGH, wdata: 8'h11};
    t0h_we <= 1'b1;
    t0h_d <= 8'h77;
    @(posedge clk);
    {t1l_we, t1h_we, t0h_we, sfr.wr} <= 4'h0;
    rd_chk("t1_low core", ADDR_T1_LOW, 8'h5A);
    rd_chk("t1_high core", ADDR_T1_HIGH, 8'h69);
    rd_chk("t0_high cpu wins", ADDR_T0_HIGH, 8'h11);
    $display("test core update done");
  endtask

  // system clock select keeps ticks high whatever the prescale code
  task automatic t_sysclk;
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_CLK_CFG, 8'h0C | 8'(c));
      repeat (3) @(posedge clk);
      repeat (4) @(negedge clk) check("sysclk ticks", {5'h0, ticks}, 8'h07);
    end
    $display("test system clock done");
  endtask

  task automatic t_prescale;
    logic [7:0] divs [3] = '{8'd12, 8'd4, 8'd48};
    for (int c = 0; c < 3; c++)
    begin
      wr(ADDR_CLK_CFG, 8'(c));
      period_chk(2, divs[c], 3'b111);
      wr(ADDR_CLK_CFG, 8'h04 | 8'(c));
      period_chk(1, divs[c], 3'b111);
      wr(ADDR_CLK_CFG, 8'h08 | 8'(c));
      period_chk(2, divs[c], 3'b111);
    end
    $display("test prescale done");
  endtask

  task automatic t_ext;
    @(posedge clk);
    ext_run <= 1'b1;
    wr(ADDR_CLK_CFG, 8'h03);
    period_chk(2, 8'd32, 3'b110);
    period_chk(1, 8'd32, 3'b110);
    @(posedge clk);
    ext_run <= 1'b0;
    $display("test external clock done");
  endtask

  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_core();
    t_sysclk();
    t_prescale();
    t_ext();
    final_report();
  end
endmodule
